// >>> serial_eeprom_command_port.sv
// serial eeprom command port: instruction decoder, memory, self-timed cycle
// assumes serial_clock_i is the host's link clock and serial_out is resolved outside
// Function
// - instructions are 11 bits in word mode, 12 in byte mode, plus write data.
// - serial_in bits are sampled on each rising serial_clock edge.
// - serial_out is high impedance except for read data or busy status.
// - selected during a cycle, serial_out is low while busy, high when ready.
// - shifting a 1 into serial_in returns status output to high impedance.
// - start bit, 2-bit opcode, address, and data for writes.
// - opcode and top address bits decode to the seven commands.
// - read sends a dummy 0 then the addressed word msb first.
// - read output bits change on rising serial_clock edges.
// - continued clocking reads the next address, wrapping to 0.
// - only the first word of a sequential read has the dummy 0.
// - powers up write locked; writes and erases rejected until unlocked.
// - unlock holds until power loss or lock; lock rejects writes, erases.
// - reads work whether locked or not.
// - deselect after a complete write starts the clear-and-store cycle.
// - the self-timed cycle completes without serial_clock edges.
// - write clears the location before storing, no erase needed.
// - erase after deselect sets every bit of the location to 1.
// - erase-all after deselect sets every memory bit to 1.
// - write-all after deselect writes its data into every location.
module serial_eeprom_command_port
    import serial_eeprom_pkg::*;
#(
    parameter int PROG_CYCLES_P = PROG_CYCLES
) (
    input wire logic sys_clk_i, // 40 MHz system clock
    input wire logic srst_i, // synchronous reset, power-up
    input wire logic chip_select_i, // device select, high active
    input wire logic serial_clock_i, // link clock from host
    input wire logic serial_in_i, // serial data in
    input wire logic width_select_i, // high: 16-bit words, low: 8-bit
    output logic serial_out_o, // serial data out
    output logic serial_out_oe_o // serial data out enable
);

    if (PROG_CYCLES_P < 2 * MEM_BYTES) begin : g_prog_cycles_check
        $error("PROG_CYCLES_P too small for a full-array sweep");
    end

    logic [BYTE_W-1:0] mem [MEM_BYTES];

    function automatic logic [WORD_W-1:0] mem_word(input logic width_select, input logic [7:0] a);
        mem_word = width_select ? {mem[{a[6:0], 1'b0}], mem[{a[6:0], 1'b1}]} : {8'h00, mem[a]};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // link domain
    logic org_meta, org_reg, lrst_meta, lrst_reg;
    link_st_e st_reg;
    cmd_e pend_cmd_reg;
    logic [CNT_W-1:0] cnt_reg, addr_w, data_w;
    logic [1:0] op_reg, sub_op;
    logic [8:0] addr_sr_reg, full_addr;
    logic [WORD_W-1:0] data_sr_reg, rd_word_reg, pend_data_reg;
    logic [7:0] rd_addr_reg, pend_addr_reg, eff_addr, next_rd_addr;
    logic [3:0] rd_idx_reg;
    logic started_reg, rd_oe_reg, rd_bit_reg, pend_tog_reg, pend_org_reg;
    logic addr_last, data_last, word_last;

    assign addr_w = org_reg ? CNT_W'(ADDR_FIELD_W16) : CNT_W'(ADDR_FIELD_W8);
    assign data_w = org_reg ? CNT_W'(WORD_W) : CNT_W'(BYTE_W);
    assign full_addr = {addr_sr_reg[7:0], serial_in_i};
    // special command from top two address bits
    assign sub_op = org_reg ? full_addr[7:6] : full_addr[8:7];
    // ignored top address bit dropped here
    assign eff_addr = full_addr[7:0] & (org_reg ? ADDR_MASK16 : ADDR_MASK8);
    assign addr_last = (st_reg == L_ADDR) && (cnt_reg == addr_w - 1'b1);
    assign data_last = (st_reg == L_DATA) && (cnt_reg == data_w - 1'b1);
    assign word_last = ({1'b0, rd_idx_reg} == data_w - 1'b1);
    // next address wraps to 0 past the last location
    assign next_rd_addr = (rd_addr_reg + 8'h01) & (org_reg ? ADDR_MASK16 : ADDR_MASK8);

    always_ff @(posedge serial_clock_i) begin
        org_meta <= width_select_i;
        org_reg <= org_meta;
        lrst_meta <= srst_i;
        lrst_reg <= lrst_meta;
    end

    // frame state, cleared while deselected
    always_ff @(posedge serial_clock_i or negedge chip_select_i) begin
        if (!chip_select_i) begin
            st_reg <= L_IDLE;
            cnt_reg <= '0;
            started_reg <= 1'b0;
            rd_oe_reg <= 1'b0;
            rd_bit_reg <= 1'b0;
        end else begin
            // every field bit taken on the rising edge
            case (st_reg)
                L_IDLE: begin
                    if (serial_in_i) begin
                        st_reg <= L_OPCODE;
                        started_reg <= 1'b1;
                        cnt_reg <= '0;
                    end
                end
                L_OPCODE: begin
                    cnt_reg <= (cnt_reg == CNT_W'(OP_BITS - 1)) ? '0 : cnt_reg + 1'b1;
                    if (cnt_reg == CNT_W'(OP_BITS - 1)) begin
                        st_reg <= L_ADDR;
                    end
                end
                L_ADDR: begin
                    cnt_reg <= addr_last ? '0 : cnt_reg + 1'b1;
                    if (addr_last) begin
                        if (op_reg == OP_READ) begin
                            // dummy 0 leads the first word
                            st_reg <= L_READ;
                            rd_oe_reg <= 1'b1;
                            rd_bit_reg <= 1'b0;
                        end else if (op_reg == OP_WRITE ||
                                     (op_reg == OP_SPECIAL && sub_op == SUB_WRITE_ALL)) begin
                            st_reg <= L_DATA;
                        end else begin
                            st_reg <= L_DONE;
                        end
                    end
                end
                L_DATA: begin
                    cnt_reg <= cnt_reg + 1'b1;
                    if (data_last) begin
                        st_reg <= L_DONE;
                    end
                end
                L_READ: begin
                    // read bits change on the rising edge
                    rd_bit_reg <= org_reg ? rd_word_reg[WORD_W-1] : rd_word_reg[BYTE_W-1];
                end
                L_DONE: st_reg <= L_DONE;
                default: st_reg <= L_IDLE;
            endcase
        end
    end

    always_ff @(posedge serial_clock_i) begin
        if (st_reg == L_OPCODE) begin
            op_reg <= {op_reg[0], serial_in_i};
        end
        if (st_reg == L_ADDR) begin
            addr_sr_reg <= full_addr;
            pend_addr_reg <= eff_addr;
        end
        if (st_reg == L_DATA) begin
            data_sr_reg <= {data_sr_reg[WORD_W-2:0], serial_in_i};
        end
    end

    // later words follow with no dummy bit
    always_ff @(posedge serial_clock_i) begin
        if (addr_last && op_reg == OP_READ) begin
            rd_addr_reg <= eff_addr;
            rd_word_reg <= mem_word(org_reg, eff_addr);
            rd_idx_reg <= '0;
        end else if (st_reg == L_READ && chip_select_i) begin
            if (word_last) begin
                rd_addr_reg <= next_rd_addr;
                rd_word_reg <= mem_word(org_reg, next_rd_addr);
                rd_idx_reg <= '0;
            end else begin
                rd_word_reg <= {rd_word_reg[WORD_W-2:0], 1'b0};
                rd_idx_reg <= rd_idx_reg + 1'b1;
            end
        end
    end

    // complete instruction posted to the system side
    always_ff @(posedge serial_clock_i) begin
        if (lrst_reg) begin
            pend_tog_reg <= 1'b0;
            pend_cmd_reg <= CMD_NONE;
        end else if ((addr_last && op_reg == OP_ERASE) ||
                     (addr_last && op_reg == OP_SPECIAL && sub_op != SUB_WRITE_ALL) ||
                     data_last) begin
            pend_tog_reg <= ~pend_tog_reg;
            pend_org_reg <= org_reg;
            if (data_last) begin
                pend_data_reg <= {data_sr_reg[WORD_W-2:0], serial_in_i};
                pend_cmd_reg <= (op_reg == OP_WRITE) ? CMD_WRITE : CMD_WRITE_ALL;
            end else begin
                case (op_reg == OP_ERASE ? SUB_ERASE_ALL : sub_op)
                    SUB_UNLOCK: pend_cmd_reg <= CMD_UNLOCK;
                    SUB_LOCK: pend_cmd_reg <= CMD_LOCK;
                    default: pend_cmd_reg <= (op_reg == OP_ERASE) ? CMD_ERASE : CMD_ERASE_ALL;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // system domain
    logic [SYNC_N-1:0] sync_meta, sync_s;
    logic cs_s, tog_s, strt_s, rdoe_s, rdbit_s, cs_d_reg, cs_fall;
    logic seen_tog_reg, unlocked_reg, busy_reg, sweep_reg, status_reg;
    logic [31:0] timer_reg;
    logic [PTR_W-1:0] ptr_reg, ptr_end_reg, lo_byte, wr_byte;
    cmd_e job_cmd_reg;
    logic [WORD_W-1:0] job_data_reg;
    logic job_org_reg, fresh, is_prog;

    always_ff @(posedge sys_clk_i) begin
        sync_meta <= {chip_select_i, pend_tog_reg, started_reg, rd_oe_reg, rd_bit_reg};
        sync_s <= sync_meta;
    end
    assign {cs_s, tog_s, strt_s, rdoe_s, rdbit_s} = sync_s;

    always_ff @(posedge sys_clk_i) begin
        cs_d_reg <= srst_i ? 1'b0 : cs_s;
    end
    assign cs_fall = cs_d_reg && !cs_s;
    assign fresh = tog_s != seen_tog_reg;
    assign is_prog = pend_cmd_reg inside {CMD_WRITE, CMD_ERASE, CMD_ERASE_ALL, CMD_WRITE_ALL};
    assign lo_byte = pend_org_reg ? {pend_addr_reg[6:0], 1'b0} : pend_addr_reg;

    // locked from power-up; unlock and lock commands
    // deselect starts the cycle; ignored while busy
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            seen_tog_reg <= tog_s;
            unlocked_reg <= 1'b0;
            busy_reg <= 1'b0;
            sweep_reg <= 1'b0;
            timer_reg <= '0;
            ptr_reg <= PTR_FIRST;
            ptr_end_reg <= PTR_FIRST;
            job_cmd_reg <= CMD_NONE;
        end else if (busy_reg) begin
            // runs on the system clock alone
            seen_tog_reg <= tog_s;
            timer_reg <= timer_reg - 1;
            busy_reg <= timer_reg != 32'h0000_0001;
            if (sweep_reg) begin
                sweep_reg <= ptr_reg != ptr_end_reg;
                ptr_reg <= ptr_reg + 1'b1;
            end
        end else if (cs_fall && fresh) begin
            seen_tog_reg <= tog_s;
            job_cmd_reg <= pend_cmd_reg;
            job_data_reg <= pend_data_reg;
            job_org_reg <= pend_org_reg;
            if (pend_cmd_reg == CMD_UNLOCK) begin
                unlocked_reg <= 1'b1;
            end else if (pend_cmd_reg == CMD_LOCK) begin
                unlocked_reg <= 1'b0;
            end else if (is_prog && unlocked_reg) begin
                busy_reg <= 1'b1;
                sweep_reg <= 1'b1;
                timer_reg <= 32'(PROG_CYCLES_P);
                if (pend_cmd_reg inside {CMD_ERASE_ALL, CMD_WRITE_ALL}) begin
                    ptr_reg <= PTR_FIRST;
                    ptr_end_reg <= PTR_LAST;
                end else begin
                    ptr_reg <= lo_byte;
                    ptr_end_reg <= lo_byte | {7'h00, pend_org_reg};
                end
            end
        end
    end

    // write overwrites the whole byte, no erase step needed
    assign wr_byte = (job_cmd_reg inside {CMD_ERASE, CMD_ERASE_ALL}) ? ERASED_BYTE :
                     (job_org_reg && !ptr_reg[0]) ? job_data_reg[15:8] : job_data_reg[7:0];
    always_ff @(posedge sys_clk_i) begin
        if (busy_reg && sweep_reg) begin
            mem[ptr_reg] <= wr_byte;
        end
    end

    // drive only read data or status; busy low, ready high
    // a started frame releases status; reads ignore lock
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            status_reg <= 1'b0;
            serial_out_o <= 1'b0;
            serial_out_oe_o <= 1'b0;
        end else begin
            if (cs_fall && fresh && !busy_reg && is_prog && unlocked_reg) begin
                status_reg <= 1'b1;
            end else if (!busy_reg && cs_s && strt_s) begin
                status_reg <= 1'b0;
            end
            if (cs_s && status_reg && !strt_s) begin
                serial_out_oe_o <= 1'b1;
                serial_out_o <= !busy_reg;
            end else begin
                serial_out_oe_o <= cs_s && rdoe_s && !busy_reg;
                serial_out_o <= rdbit_s;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_polled;
        cs_s && status_reg && !strt_s;
    endsequence
    sequence s_prog_start;
        cs_fall && fresh && !busy_reg && is_prog;
    endsequence

    chk_hiz_deselect: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        !cs_s |=> !serial_out_oe_o) else $error("serial_out driven while deselected");
    chk_busy_low: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        s_polled and busy_reg |=> serial_out_oe_o && !serial_out_o)
        else $error("busy not shown low");
    chk_ready_high: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        s_polled and !busy_reg |=> serial_out_oe_o && serial_out_o)
        else $error("ready not shown high");
    chk_status_release: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        cs_s && strt_s && !rdoe_s |=> !serial_out_oe_o) else $error("status not released");
    chk_locked_reject: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        s_prog_start and !unlocked_reg |=> !busy_reg) else $error("locked write started");
    chk_unlocked_start: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        s_prog_start and unlocked_reg |=> busy_reg && sweep_reg ##1 busy_reg)
        else $error("program cycle not started");
    chk_busy_ignore: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        busy_reg |=> $stable(unlocked_reg)) else $error("command taken while busy");
    chk_powerup_lock: assert property (@(posedge sys_clk_i)
        $past(srst_i) |-> !unlocked_reg && !busy_reg) else $error("not locked after reset");
    chk_cycle_ends: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        busy_reg && timer_reg == 32'h0000_0001 |=> !busy_reg) else $error("cycle did not end");
    chk_read_dummy: assert property (@(posedge serial_clock_i) disable iff (!chip_select_i)
        addr_last && op_reg == OP_READ |=> rd_oe_reg && !rd_bit_reg)
        else $error("read dummy bit missing");

endmodule

// >>> serial_eeprom_pkg.sv
// constants, opcodes and state types of the serial eeprom command port
// assumes a 40 MHz system clock; the serial link runs on its own clock
package serial_eeprom_pkg;

    localparam int MEM_BYTES = 256;
    localparam int PTR_W = 8;
    localparam int WORD_W = 16;
    localparam int BYTE_W = 8;
    localparam int ADDR_FIELD_W16 = 8;
    localparam int ADDR_FIELD_W8 = 9;
    localparam int CNT_W = 5;
    localparam int OP_BITS = 2;
    localparam int SYNC_N = 5;

    localparam logic [1:0] OP_SPECIAL = 2'b00;
    localparam logic [1:0] OP_WRITE = 2'b01;
    localparam logic [1:0] OP_READ = 2'b10;
    localparam logic [1:0] OP_ERASE = 2'b11;
    localparam logic [1:0] SUB_LOCK = 2'b00;
    localparam logic [1:0] SUB_WRITE_ALL = 2'b01;
    localparam logic [1:0] SUB_ERASE_ALL = 2'b10;
    localparam logic [1:0] SUB_UNLOCK = 2'b11;

    localparam logic [7:0] ADDR_MASK16 = 8'h7F;
    localparam logic [7:0] ADDR_MASK8 = 8'hFF;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [7:0] PTR_FIRST = 8'h00;
    localparam logic [7:0] PTR_LAST = 8'hFF;

    // self-timed program/erase cycle, longest time rounds down
    localparam int SYS_CLK_HZ = 40_000_000;
    localparam int PROG_TIME_MS = 5;
    localparam int PROG_CYCLES = PROG_TIME_MS * (SYS_CLK_HZ / 1000);
    // power-up wait before first instruction, kept by the host
    localparam int POWER_UP_TIME_MS = 1;

    typedef enum logic [2:0] {
        CMD_NONE, CMD_WRITE, CMD_ERASE, CMD_UNLOCK, CMD_LOCK, CMD_ERASE_ALL, CMD_WRITE_ALL
    } cmd_e;

    typedef enum logic [2:0] {
        L_IDLE, L_OPCODE, L_ADDR, L_DATA, L_READ, L_DONE
    } link_st_e;

endpackage

// >>> serial_eeprom_host_model.sv
// host side of the serial eeprom link: select, link clock and serial data
// assumes the caller hands in the resolved serial_out line; paced by sys_clk_i
module serial_eeprom_host_model
    import serial_eeprom_pkg::*;
(
    input wire logic sys_clk_i, // pacing clock
    input wire logic data_i, // resolved serial_out line
    output logic chip_select_o, // device select
    output logic serial_clock_o, // link clock, low between pulses
    output logic serial_in_o // serial data to device
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        chip_select_o = 1'b0;
        serial_clock_o = 1'b0;
        serial_in_o = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // one 10 ns link clock period, off phase from the system clock
    task automatic pulse();
        @(negedge sys_clk_i);
        #7 serial_clock_o = 1'b1;
        #3 serial_clock_o = 1'b0;
    endtask

    // shift n bits msb first, sampling the line just before each rise
    task automatic xfer(input logic [63:0] v, input int n, output logic [63:0] r);
        r = '0;
        for (int i = n - 1; i >= 0; i--) begin
            @(negedge sys_clk_i);
            // data settled well before the rise
            serial_in_o = v[i];
            repeat (6) @(negedge sys_clk_i);
            r = {r[62:0], data_i};
            pulse();
            repeat (4) @(negedge sys_clk_i);
        end
    endtask

    task automatic select();
        @(negedge sys_clk_i);
        chip_select_o = 1'b1;
        repeat (2) @(negedge sys_clk_i);
    endtask

    task automatic deselect();
        @(negedge sys_clk_i);
        chip_select_o = 1'b0;
        serial_in_o = ~serial_in_o;
        repeat (12) @(negedge sys_clk_i);
    endtask
endmodule

// >>> serial_eeprom_command_port_tb_top.sv
// self-checking bench of the serial eeprom command port
// assumes the host model drives the link; serial_out resolved here
module serial_eeprom_command_port_tb_top
    import serial_eeprom_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic sys_clk, srst, width_sel, so, soe, cs, sclk, di;
    wire dout = soe ? so : 1'bz;
    int n_errors = 0;
    int checks = 0;

    serial_eeprom_command_port #(.PROG_CYCLES_P(600)) dut (.sys_clk_i(sys_clk), .srst_i(srst),
        .chip_select_i(cs), .serial_clock_i(sclk), .serial_in_i(di),
        .width_select_i(width_sel), .serial_out_o(so), .serial_out_oe_o(soe));
    serial_eeprom_host_model host (.sys_clk_i(sys_clk), .data_i(dout), .chip_select_o(cs),
        .serial_clock_o(sclk), .serial_in_o(di));

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        if (n_errors == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cmd(input logic [63:0] v, input int n);
        logic [63:0] r;
        host.select();
        host.xfer(v, n, r);
        host.deselect();
    endtask

    task automatic rd(input logic [63:0] v, input int n, input int nb, output logic [63:0] r);
        logic [63:0] t;
        host.select();
        host.xfer(v, n, t);
        host.xfer(64'h0, nb, r);
        host.deselect();
    endtask

    task automatic wait_ready();
        logic [63:0] r;
        int k;
        check(soe, 1'b0);
        host.select();
        repeat (6) @(negedge sys_clk);
        check({soe, dout}, 2'b10);
        k = 0;
        while (dout !== 1'b1 && k < 2000) begin
            @(negedge sys_clk);
            k++;
        end
        check({soe, dout}, 2'b11);
        // shifting in a start bit releases the status output
        host.xfer(64'h1, 1, r);
        repeat (4) @(negedge sys_clk);
        check(soe, 1'b0);
        host.deselect();
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_locked();
        check(soe, 1'b0);
        cmd({1'b1, OP_WRITE, 8'h03, 16'h0000}, 27);
        host.select();
        repeat (8) @(negedge sys_clk);
        check(soe, 1'b0);
        host.deselect();
    endtask

    task automatic t_erase_all();
        logic [63:0] r;
        cmd({1'b1, OP_SPECIAL, SUB_UNLOCK, 6'h00}, 11);
        cmd({1'b1, OP_SPECIAL, SUB_ERASE_ALL, 6'h00}, 11);
        wait_ready();
        rd({1'b1, OP_READ, 8'h40}, 11, 33, r);
        check(r, {31'h0, 1'b0, 16'hFFFF, 16'hFFFF});
    endtask

    task automatic t_write();
        logic [63:0] r;
        cmd({1'b1, OP_WRITE, 8'h05, 16'h0F0F}, 27);
        wait_ready();
        cmd({1'b1, OP_WRITE, 8'h05, 16'hF0F0}, 27);
        wait_ready();
        rd({1'b1, OP_READ, 8'h05}, 11, 17, r);
        check(r, {47'h0, 1'b0, 16'hF0F0});
    endtask

    task automatic t_seq();
        logic [63:0] r;
        cmd({1'b1, OP_WRITE, 8'h7F, 16'hBEEF}, 27);
        wait_ready();
        cmd({1'b1, OP_WRITE, 8'h00, 16'h1357}, 27);
        wait_ready();
        // unused top address bit driven to a definite 1
        rd({1'b1, OP_READ, 8'hFF}, 11, 33, r);
        check(r, {31'h0, 1'b0, 16'hBEEF, 16'h1357});
        check(soe, 1'b0);
    endtask

    task automatic t_erase();
        logic [63:0] r;
        cmd({1'b1, OP_ERASE, 8'h05}, 11);
        wait_ready();
        rd({1'b1, OP_READ, 8'h05}, 11, 17, r);
        check(r, {47'h0, 1'b0, 16'hFFFF});
    endtask

    task automatic t_x8();
        logic [63:0] r;
        @(negedge sys_clk);
        width_sel = 1'b0;
        cmd({1'b1, OP_WRITE, 9'h00B, 8'h3C}, 20);
        wait_ready();
        rd({1'b1, OP_READ, 9'h00A}, 12, 17, r);
        check(r, {47'h0, 1'b0, 8'hFF, 8'h3C});
        @(negedge sys_clk);
        width_sel = 1'b1;
        rd({1'b1, OP_READ, 8'h05}, 11, 17, r);
        check(r, {47'h0, 1'b0, 16'hFF3C});
    endtask

    task automatic t_busy();
        logic [63:0] r;
        cmd({1'b1, OP_SPECIAL, SUB_WRITE_ALL, 6'h00, 16'hC0DE}, 27);
        cmd({1'b1, OP_WRITE, 8'h00, 16'h0000}, 27);
        repeat (700) @(negedge sys_clk);
        rd({1'b1, OP_READ, 8'h00}, 11, 33, r);
        check(r, {31'h0, 1'b0, 16'hC0DE, 16'hC0DE});
    endtask

    task automatic t_lock();
        logic [63:0] r;
        cmd({1'b1, OP_SPECIAL, SUB_LOCK, 6'h00}, 11);
        cmd({1'b1, OP_ERASE, 8'h00}, 11);
        host.select();
        repeat (8) @(negedge sys_clk);
        check(soe, 1'b0);
        host.deselect();
        rd({1'b1, OP_READ, 8'h00}, 11, 17, r);
        check(r, {47'h0, 1'b0, 16'hC0DE});
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #2_000_000;
        n_errors++;
        conclude();
    end

    initial begin
        srst = 1'b1;
        width_sel = 1'b1;
        fork
            repeat (10) @(negedge sys_clk);
            repeat (4) host.pulse();
        join
        srst = 1'b0;
        // short wait after power-up before the first frame
        repeat (4) @(negedge sys_clk);
        t_locked();
        t_erase_all();
        t_write();
        t_seq();
        t_erase();
        t_x8();
        t_busy();
        t_lock();
        conclude();
    end
endmodule
